// File: hdl/map_pkg.sv
// constants, modes and carrier structs of the paged address mapping unit
package map_pkg;
    localparam int VA_W          = 24;
    localparam int PAGE_OFF_W    = 11;
    localparam int VPN_W         = 13;
    localparam int DIR_ENTRIES   = 16;
    localparam int DIR_IDX_W     = 4;
    localparam int FRAME_W       = 8;
    localparam int PSA_W         = 19;
    localparam int EXT_W         = 5;
    localparam int CFG_W         = 8;
    localparam int SEG_IDX_W     = 8;
    localparam int PG_IDX_W      = 9;
    // field positions of the segmented virtual address
    localparam int SEG_SMALL_LSB = 16;
    localparam int SEG_LARGE_LSB = 20;
    localparam int PAGE_2K_LSB   = 11;
    localparam int PAGE_4K_LSB   = 12;
    // reset values
    localparam logic [FRAME_W-1:0] FRAME_RESET = 8'h00;
    localparam logic [CFG_W-1:0]   CFG_RESET   = 8'h00;

    typedef enum logic [1:0] {ref_operand, ref_implicit, ref_table, ref_translated} ref_kind_t;
    typedef enum logic [1:0] {cmd_map, cmd_unmap, cmd_reset_ref, cmd_query} cmd_op_t;
    typedef enum logic [1:0] {
        fault_none, fault_page_translation, fault_page_access, fault_addressing
    } fault_t;

    typedef struct packed {
        logic            valid;
        ref_kind_t       kind;
        logic            write;
        logic            pte_invalid;
        logic [VA_W-1:0] addr;
    } req_t;

    typedef struct packed {
        logic                 valid;
        fault_t               fault;
        logic                 suppress;
        logic [PSA_W-1:0]     ps_addr;
        logic [SEG_IDX_W-1:0] seg_index;
        logic [PG_IDX_W-1:0]  page_index;
    } resp_t;

    typedef struct packed {
        logic               valid;
        cmd_op_t            op;
        logic [VPN_W-1:0]   page;
        logic [FRAME_W-1:0] frame;
    } cmd_t;

    typedef struct packed {
        logic               valid;
        logic               resident;
        logic               referenced;
        logic               changed;
        logic [FRAME_W-1:0] frame;
    } cmd_resp_t;
endpackage

// File: hdl/paged_address_mapping_unit.sv
// paged address mapping unit: storage directory, page faults, reference and change bits
`timescale 1ns/10ps
module paged_address_mapping_unit (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // operator configuration pins, asynchronous
    input  wire logic                          assist_mode,
    input  wire logic                          seg_large,
    input  wire logic                          page_4k,
    input  wire logic [map_pkg::EXT_W-1:0]     extent,
    // storage reference from instruction execution
    input  wire map_pkg::req_t                 req,
    output map_pkg::resp_t                     resp,
    // page-handling command port
    input  wire map_pkg::cmd_t                 cmd,
    output map_pkg::cmd_resp_t                 cmd_resp
);
    logic [map_pkg::CFG_W-1:0]   cfg_meta_reg;
    logic [map_pkg::CFG_W-1:0]   cfg_reg;
    logic                        assist_s;
    logic                        seg_large_s;
    logic                        page_4k_s;
    logic [map_pkg::EXT_W-1:0]   extent_s;

    logic [map_pkg::DIR_ENTRIES-1:0]                      resident_reg;
    logic [map_pkg::DIR_ENTRIES-1:0][map_pkg::FRAME_W-1:0] frame_reg;
    logic [map_pkg::DIR_ENTRIES-1:0]                      ref_reg;
    logic [map_pkg::DIR_ENTRIES-1:0]                      chg_reg;

    map_pkg::resp_t              resp_reg;
    map_pkg::resp_t              resp_next;
    map_pkg::cmd_resp_t          cmd_resp_reg;
    map_pkg::cmd_resp_t          cmd_resp_next;

    logic [map_pkg::VPN_W-1:0]     req_vpn;
    logic [map_pkg::DIR_IDX_W-1:0] req_idx;
    logic                          req_in_extent;
    logic                          req_ok;
    logic [map_pkg::DIR_IDX_W-1:0] cmd_idx;
    logic                          cmd_in_extent;

    // configuration pins pass two flops; the first stage feeds only the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_meta_reg <= map_pkg::CFG_RESET;
            cfg_reg      <= map_pkg::CFG_RESET;
        end else begin
            cfg_meta_reg <= {assist_mode, seg_large, page_4k, extent};
            cfg_reg      <= cfg_meta_reg;
        end
    end

    // unpack in the same order the pins were packed, so no field position is spelled out
    assign {assist_s, seg_large_s, page_4k_s, extent_s} = cfg_reg;

    // directory index is a 2K page number in both modes
    assign req_vpn = req.addr[map_pkg::VA_W-1:map_pkg::PAGE_OFF_W];
    assign req_idx = req_vpn[map_pkg::DIR_IDX_W-1:0];
    // entries past the configured extent simply do not exist
    assign req_in_extent = ({8'h00, extent_s} > req_vpn) &&
                           (req_vpn < 13'(map_pkg::DIR_ENTRIES));
    assign cmd_idx       = cmd.page[map_pkg::DIR_IDX_W-1:0];
    assign cmd_in_extent = ({8'h00, extent_s} > cmd.page) &&
                           (cmd.page < 13'(map_pkg::DIR_ENTRIES));
    // the access really reaches storage only without a fault
    assign req_ok = req.valid && (resp_next.fault == map_pkg::fault_none);

    // lookup and fault decision; the directory is only ever an index, never data
    always_comb begin
        resp_next            = '0;
        resp_next.valid      = req.valid;
        // directory frame replaces the page number; the offset passes through
        resp_next.ps_addr    = {frame_reg[req_idx], req.addr[map_pkg::PAGE_OFF_W-1:0]};
        if (assist_s) begin
            // no segment level; table and translated references are addressing faults, and the entry alone decides page access
            if (req.kind == map_pkg::ref_table || req.kind == map_pkg::ref_translated) begin
                resp_next.fault = map_pkg::fault_addressing;
            end else if (!req_in_extent || !resident_reg[req_idx]) begin
                resp_next.fault = map_pkg::fault_page_access;
            end
        end else begin
            // segment and page fields of the virtual address for the table walk
            if (seg_large_s) begin
                resp_next.seg_index = {4'h0, req.addr[map_pkg::VA_W-1:map_pkg::SEG_LARGE_LSB]};
                if (page_4k_s) begin
                    resp_next.page_index = {1'b0, req.addr[map_pkg::SEG_LARGE_LSB-1:
                                                            map_pkg::PAGE_4K_LSB]};
                end else begin
                    resp_next.page_index = req.addr[map_pkg::SEG_LARGE_LSB-1:
                                                    map_pkg::PAGE_2K_LSB];
                end
            end else begin
                resp_next.seg_index = req.addr[map_pkg::VA_W-1:map_pkg::SEG_SMALL_LSB];
                if (page_4k_s) begin
                    resp_next.page_index = {5'h00, req.addr[map_pkg::SEG_SMALL_LSB-1:
                                                            map_pkg::PAGE_4K_LSB]};
                end else begin
                    resp_next.page_index = {4'h0, req.addr[map_pkg::SEG_SMALL_LSB-1:
                                                           map_pkg::PAGE_2K_LSB]};
                end
            end
            // a missing page table entry is reported before any real address exists
            if (req.kind == map_pkg::ref_translated && req.pte_invalid) begin
                resp_next.fault = map_pkg::fault_page_translation;
            end else if (!req_in_extent || !resident_reg[req_idx]) begin
                resp_next.fault = map_pkg::fault_addressing;
            end
        end
        if (!req.valid) begin
            resp_next.fault = map_pkg::fault_none;
        end
        // a faulting access goes nowhere; instruction stays restartable
        resp_next.suppress = (resp_next.fault != map_pkg::fault_none);
        if (resp_next.suppress) begin
            resp_next.ps_addr = '0;
        end
    end

    // response register keeps every output straight from a flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            resp_reg <= '0;
        end else begin
            resp_reg <= resp_next;
        end
    end

    // per-entry directory state; the request port writes only the reference and change bits
    for (genvar i = 0; i < map_pkg::DIR_ENTRIES; i++) begin : g_entry
        logic hit_cmd;
        logic hit_req;
        // the command port selects an entry here; hit_req selects it for the request port
        assign hit_cmd = cmd.valid && cmd_in_extent &&
                         (cmd_idx == (map_pkg::DIR_IDX_W)'(i));
        assign hit_req = req_ok && (req_idx == (map_pkg::DIR_IDX_W)'(i));

        // resident flag and frame change only by page-handling commands
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                resident_reg[i] <= 1'b0;
                frame_reg[i]    <= map_pkg::FRAME_RESET;
            end else if (hit_cmd && cmd.op == map_pkg::cmd_map) begin
                resident_reg[i] <= 1'b1;
                frame_reg[i]    <= cmd.frame;
            end else if (hit_cmd && cmd.op == map_pkg::cmd_unmap) begin
                resident_reg[i] <= 1'b0;
            end
        end

        // a reference in the clearing cycle wins, so no activity is ever lost
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                ref_reg[i] <= 1'b0;
                chg_reg[i] <= 1'b0;
            end else if (hit_req) begin
                ref_reg[i] <= 1'b1;
                chg_reg[i] <= chg_reg[i] | req.write;
            end else if (hit_cmd && (cmd.op == map_pkg::cmd_reset_ref ||
                                     cmd.op == map_pkg::cmd_map)) begin
                ref_reg[i] <= 1'b0;
                chg_reg[i] <= 1'b0;
            end
        end
    end

    // command answer shows the entry state before the command takes effect
    always_comb begin
        cmd_resp_next            = '0;
        cmd_resp_next.valid      = cmd.valid;
        if (cmd.valid && cmd_in_extent) begin
            cmd_resp_next.resident   = resident_reg[cmd_idx];
            cmd_resp_next.referenced = ref_reg[cmd_idx];
            cmd_resp_next.changed    = chg_reg[cmd_idx];
            cmd_resp_next.frame      = frame_reg[cmd_idx];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_resp_reg <= '0;
        end else begin
            cmd_resp_reg <= cmd_resp_next;
        end
    end

    assign resp     = resp_reg;
    assign cmd_resp = cmd_resp_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_seg_real_map: assert property (
        req.valid && !assist_s && req.kind == map_pkg::ref_table && req_in_extent &&
        resident_reg[req_idx]
        |=> resp_reg.valid && resp_reg.fault == map_pkg::fault_none &&
            resp_reg.ps_addr == {$past(frame_reg[req_idx]),
                                 $past(req.addr[map_pkg::PAGE_OFF_W-1:0])})
        else $error("segmented real address not mapped through directory");
    chk_assist_direct_map: assert property (
        req.valid && assist_s && req.kind == map_pkg::ref_operand && req_in_extent &&
        resident_reg[req_idx]
        |=> resp_reg.fault == map_pkg::fault_none &&
            resp_reg.ps_addr[map_pkg::PSA_W-1:map_pkg::PAGE_OFF_W] == $past(frame_reg[req_idx]))
        else $error("assist page not mapped to its frame");
    chk_map_command: assert property (
        cmd.valid && cmd_in_extent && cmd.op == map_pkg::cmd_map
        |=> resident_reg[$past(cmd_idx)] && frame_reg[$past(cmd_idx)] == $past(cmd.frame))
        else $error("map command did not fill the entry");
    chk_extent_limit: assert property (
        req.valid && !req_in_extent && req.kind != map_pkg::ref_translated
        |=> resp_reg.fault != map_pkg::fault_none)
        else $error("page beyond extent was mapped");
    chk_directory_stable: assert property (
        !cmd.valid |=> $stable(resident_reg) && $stable(frame_reg))
        else $error("directory changed without a command");
    chk_pte_fault: assert property (
        req.valid && !assist_s && req.kind == map_pkg::ref_translated && req.pte_invalid
        |=> resp_reg.fault == map_pkg::fault_page_translation)
        else $error("page translation exception missing");
    chk_access_fault: assert property (
        req.valid && assist_s && (req.kind == map_pkg::ref_operand ||
        req.kind == map_pkg::ref_implicit) && !resident_reg[req_idx]
        |=> resp_reg.fault == map_pkg::fault_page_access)
        else $error("page access exception missing");
    chk_ref_change: assert property (
        req_ok && req.write |=> ref_reg[$past(req_idx)] && chg_reg[$past(req_idx)])
        else $error("reference or change bit not set");
    chk_fault_suppress: assert property (
        resp_reg.valid |-> (resp_reg.suppress == (resp_reg.fault != map_pkg::fault_none)) &&
        (!resp_reg.suppress || resp_reg.ps_addr == '0))
        else $error("faulting access not suppressed");
endmodule // paged_address_mapping_unit

// File: verif/paged_address_mapping_unit_tb_top.sv
// self-checking testbench of the paged address mapping unit
`timescale 1ns/10ps
module paged_address_mapping_unit_tb_top;
    logic                      clk         = 1'b0;
    logic                      reset       = 1'b1;
    logic                      assist_mode = 1'b1;
    logic                      seg_large   = 1'b0;
    logic                      page_4k     = 1'b0;
    logic [map_pkg::EXT_W-1:0] extent      = 5'h04;
    map_pkg::req_t             req         = '0;
    map_pkg::resp_t            resp;
    map_pkg::cmd_t             cmd         = '0;
    map_pkg::cmd_resp_t        cmd_resp;
    map_pkg::resp_t            last_r;
    map_pkg::cmd_resp_t        last_c;
    int                        n_errors    = 0;
    int                        n_checks    = 0;
    int                        exp_acc     = 0;
    int                        exp_flt     = 0;
    int                        acc_cnt;
    int                        flt_cnt;

    paged_address_mapping_unit DUT (.clk(clk), .reset(reset), .assist_mode(assist_mode),
        .seg_large(seg_large), .page_4k(page_4k), .extent(extent), .req(req), .resp(resp),
        .cmd(cmd), .cmd_resp(cmd_resp));
    storage_side_model storage (.clk(clk), .reset(reset), .resp(resp),
        .access_count(acc_cnt), .fault_count(flt_cnt));

    // 50 MHz clock
    always #10 clk = ~clk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
        n_checks++;
        if (seen !== expd) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, expd, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // config pins pass a two-flop synchroniser, so give them four edges
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask

    // one reference; answer is awaited for a bounded number of cycles
    task automatic acc(input map_pkg::ref_kind_t k, input logic w, input logic p,
                       input logic [23:0] a, input map_pkg::fault_t f, input logic [18:0] psa);
        int i;
        @(negedge clk);
        req = '{valid: 1'b1, kind: k, write: w, pte_invalid: p, addr: a};
        @(negedge clk);
        req.valid = 1'b0;
        for (i = 0; i < 3 && resp.valid !== 1'b1; i++) @(negedge clk);
        last_r = resp;
        if (f == map_pkg::fault_none) exp_acc++;
        else exp_flt++;
        check("resp valid", last_r.valid, 1'b1);
        check("resp fault", last_r.fault, f);
        check("resp suppress", last_r.suppress, f != map_pkg::fault_none);
        check("resp ps_addr", last_r.ps_addr, psa);
    endtask

    task automatic command(input map_pkg::cmd_op_t o, input logic [12:0] pg, input logic [7:0] fr);
        int i;
        @(negedge clk);
        cmd = '{valid: 1'b1, op: o, page: pg, frame: fr};
        @(negedge clk);
        cmd.valid = 1'b0;
        for (i = 0; i < 3 && cmd_resp.valid !== 1'b1; i++) @(negedge clk);
        last_c = cmd_resp;
        check("cmd_resp valid", last_c.valid, 1'b1);
    endtask

    // expected entry fields {resident, referenced, changed, frame}
    task automatic query(input logic [12:0] pg, input logic [10:0] expd);
        command(map_pkg::cmd_query, pg, 8'h00);
        check("entry state", last_c[10:0], expd);
    endtask

    task automatic t_assist();
        acc(map_pkg::ref_operand, 0, 0, 24'h000923, map_pkg::fault_page_access, 0);
        acc(map_pkg::ref_implicit, 0, 0, 24'h000923, map_pkg::fault_page_access, 0);
        command(map_pkg::cmd_map, 13'h0001, 8'h5a);
        check("map prior resident", last_c.resident, 1'b0);
        acc(map_pkg::ref_operand, 0, 0, 24'h000923, map_pkg::fault_none, 19'h2d123);
        acc(map_pkg::ref_implicit, 0, 0, 24'h000fff, map_pkg::fault_none, 19'h2d7ff);
        acc(map_pkg::ref_table, 0, 0, 24'h000923, map_pkg::fault_addressing, 0);
        check("assist page_index", last_r.page_index, 0);
        $display("test assist lookup done");
    endtask

    task automatic t_refchg();
        query(13'h0001, {3'b110, 8'h5a});
        acc(map_pkg::ref_operand, 1, 0, 24'h000900, map_pkg::fault_none, 19'h2d100);
        query(13'h0001, {3'b111, 8'h5a});
        command(map_pkg::cmd_reset_ref, 13'h0001, 8'h00);
        query(13'h0001, {3'b100, 8'h5a});
        $display("test reference and change done");
    endtask

    task automatic t_extent();
        command(map_pkg::cmd_map, 13'h0004, 8'h33);
        check("out of extent map", last_c[10:0], 0);
        query(13'h0004, 11'h000);
        acc(map_pkg::ref_operand, 0, 0, 24'h002000, map_pkg::fault_page_access, 0);
        acc(map_pkg::ref_operand, 0, 0, 24'h001804, map_pkg::fault_page_access, 0);
        command(map_pkg::cmd_map, 13'h0003, 8'h11);
        acc(map_pkg::ref_operand, 0, 0, 24'h001804, map_pkg::fault_none, 19'h08804);
        extent = 5'h03;
        settle();
        acc(map_pkg::ref_operand, 0, 0, 24'h001804, map_pkg::fault_page_access, 0);
        extent = 5'h04;
        settle();
        $display("test extent done");
    endtask

    task automatic t_unmap();
        command(map_pkg::cmd_unmap, 13'h0001, 8'h00);
        acc(map_pkg::ref_operand, 0, 0, 24'h000923, map_pkg::fault_page_access, 0);
        query(13'h0001, {3'b000, 8'h5a});
        $display("test unmap done");
    endtask

    // mid-run reset: directory must empty and the pins be seen again after resync
    task automatic t_reset();
        @(negedge clk);
        check("accesses before reset", acc_cnt, exp_acc);
        check("faults before reset", flt_cnt, exp_flt);
        reset = 1'b1;
        @(negedge clk);
        check("resp in reset", {resp.valid, resp.fault, resp.ps_addr}, 0);
        check("cmd_resp in reset", cmd_resp, 0);
        reset = 1'b0;
        exp_acc = 0;
        exp_flt = 0;
        settle();
        query(13'h0001, 11'h000);
        acc(map_pkg::ref_operand, 0, 0, 24'h001804, map_pkg::fault_page_access, 0);
        $display("test reset done");
    endtask

    task automatic t_segmented();
        logic [8:0] pidx [4] = '{9'h003, 9'h001, 9'h003, 9'h001};
        int         m;
        assist_mode = 1'b0;
        extent = 5'h10;
        settle();
        command(map_pkg::cmd_map, 13'h0003, 8'h22);
        acc(map_pkg::ref_table, 0, 0, 24'h001a5c, map_pkg::fault_none, 19'h1125c);
        acc(map_pkg::ref_translated, 0, 1, 24'h001a5c, map_pkg::fault_page_translation, 0);
        acc(map_pkg::ref_translated, 0, 0, 24'h003000, map_pkg::fault_addressing, 0);
        // every segment and page size pairing, small segments first
        for (m = 0; m < 4; m++) begin
            seg_large = m[1];
            page_4k = m[0];
            settle();
            acc(map_pkg::ref_translated, 0, 0, 24'h001a5c, map_pkg::fault_none, 19'h1125c);
            check("seg_index", last_r.seg_index, 0);
            check("page_index", last_r.page_index, pidx[m]);
        end
        $display("test segmented done");
    endtask

    // watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #100000;
        n_errors++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        settle();
        t_assist();
        t_refchg();
        t_extent();
        t_unmap();
        t_reset();
        t_segmented();
        repeat (2) @(negedge clk);
        check("storage accesses", acc_cnt, exp_acc);
        check("suppressed faults", flt_cnt, exp_flt);
        give_verdict();
    end
endmodule // paged_address_mapping_unit_tb_top

// File: verif/storage_side_model.sv
// behavioural model of processor storage behind the mapping unit: tallies answered references
`timescale 1ns/10ps
module storage_side_model (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           reset,
    // answers from the mapping unit
    input  wire map_pkg::resp_t resp,
    // tallies for the bench
    output int                  access_count,
    output int                  fault_count
);
    // a suppressed answer never reaches storage, so it only counts as a fault
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            access_count <= 0;
            fault_count  <= 0;
        end else if (resp.valid && resp.suppress) begin
            fault_count <= fault_count + 1;
        end else if (resp.valid) begin
            access_count <= access_count + 1;
        end
    end
endmodule // storage_side_model
